// File: logic/nsttr_pkg.sv
// constants for the status, transmit length and tuning register group
`default_nettype none
package nsttr_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_TARGET_STATE = 8'h21;
  localparam logic [7:0] ADDR_TX_CNT_HIGH  = 8'h22;
  localparam logic [7:0] ADDR_TX_CNT_LOW   = 8'h23;
  localparam logic [7:0] ADDR_RATE_TIMER   = 8'h24;
  localparam logic [7:0] ADDR_CONV_RESULT  = 8'h25;
  localparam logic [7:0] ADDR_DAC_A        = 8'h26;
  localparam logic [7:0] ADDR_DAC_B        = 8'h27;
  // ==========================================================
  // field positions
  localparam int TXLOW_CNT_LSB  = 3;
  localparam int TXLOW_RES_MSB  = 2;
  localparam int RATE_LSB       = 4;
  localparam int TX_CNT_W       = 13;
  localparam int TX_RES_W       = 3;
  // ==========================================================
  // reset values
  localparam logic [12:0] TX_CNT_RST = 13'h0000;
  localparam logic [2:0]  TX_RES_RST = 3'h0;
  localparam logic [7:0]  DAC_RST    = 8'h80;
  localparam logic [7:0]  CONV_RST   = 8'h00;
  localparam logic [3:0]  STATE_RST  = 4'h0;
  // ==========================================================
  // target states
  localparam logic [3:0] ST_POWER_OFF = 4'h0;
  localparam logic [3:0] ST_IDLE      = 4'h1;
  localparam logic [3:0] ST_READY1    = 4'h2;
  localparam logic [3:0] ST_READY2    = 4'h3;
  localparam logic [3:0] ST_ACTIVE    = 4'h5;
  localparam logic [3:0] ST_HALT      = 4'h9;
  localparam logic [3:0] ST_READY1_S  = 4'hA;
  localparam logic [3:0] ST_READY2_S  = 4'hB;
  localparam logic [3:0] ST_ACTIVE_S  = 4'hD;

  function automatic logic nsttr_state_valid(input logic [3:0] s);
    case (s)
      ST_POWER_OFF, ST_IDLE, ST_READY1, ST_READY2, ST_ACTIVE, ST_HALT,
      ST_READY1_S, ST_READY2_S, ST_ACTIVE_S: nsttr_state_valid = 1'b1;
      default: nsttr_state_valid = 1'b0;
    endcase
  endfunction

  function automatic logic nsttr_is_active(input logic [3:0] s);
    nsttr_is_active = (s == ST_ACTIVE) || (s == ST_ACTIVE_S);
  endfunction
endpackage
`default_nettype wire

// File: logic/nsttr_regs.sv
// status, transmit length and antenna tuning register group
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - the 4-bit target state field shows the ISO-A target state and never a reserved code.
// - in active or active-star state the host, not the device, answers all commands.
// - the 13-bit full byte count is the high register plus low bits 7..3, reset zero.
// - low register bits 2..0 count extra bits after the last full byte, zero for none.
// - residual bits go out lsb first with parity generation switched off.
// - anticollision set, card idle and residual nonzero raise parity error on reqa/wupa.
// - short or split frames work only for ISO-A/B started by transmit without crc.
// - read-only bits 5..4 show the bit rate found by automatic detection.
// - bits 3..0 read one while the field wait, general, no-response and mask timers run.
// - a read-only register holds the last completed conversion result.
// - tuning code a is read/write, resets to 0x80 and drives converter a.
// - tuning code b is read/write, resets to 0x80 and drives converter b.
module nsttr_regs (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output var  logic [7:0]  reg_rdata_ff,
  input  wire logic [3:0]  target_state_in,
  input  wire logic [1:0]  detected_rate,
  input  wire logic        field_wait_timer_running,
  input  wire logic        gp_timer_running,
  input  wire logic        no_resp_timer_running,
  input  wire logic        mask_rx_timer_running,
  input  wire logic [7:0]  conv_data,
  input  wire logic        conv_done,
  input  wire logic        anticoll_ctl,
  input  wire logic        reqa_wupa_cmd,
  input  wire logic        tx_nocrc_cmd,
  input  wire logic        tx_crc_cmd,
  input  wire logic        iso_ab_mode,
  output var  logic        auto_answer_en_ff,
  output var  logic        parity_err_irq_ff,
  output var  logic [12:0] tx_byte_count_ff,
  output var  logic [2:0]  tx_residual_ff,
  output var  logic [2:0]  tx_last_bits_ff,
  output var  logic        tx_parity_gen_ff,
  output var  logic        tx_lsb_first_ff,
  output var  logic [7:0]  dac_a_code_ff,
  output var  logic [7:0]  dac_b_code_ff
);
  import nsttr_pkg::*;

  // ==========================================================
  // next state
  logic [3:0]  state_ff, nxt_state;
  logic [7:0]  conv_ff, nxt_conv;
  logic [7:0]  nxt_rdata, nxt_dac_a, nxt_dac_b;
  logic [12:0] nxt_cnt;
  logic [2:0]  nxt_res, nxt_last_bits;
  logic        nxt_auto, nxt_perr, nxt_par_gen, nxt_lsb_first;

  always_comb begin
    nxt_state     = state_ff;
    nxt_conv      = conv_ff;
    nxt_cnt       = tx_byte_count_ff;
    nxt_res       = tx_residual_ff;
    nxt_dac_a     = dac_a_code_ff;
    nxt_dac_b     = dac_b_code_ff;
    nxt_last_bits = tx_last_bits_ff;
    nxt_par_gen   = tx_parity_gen_ff;
    nxt_lsb_first = tx_lsb_first_ff;
    nxt_rdata     = reg_rdata_ff;
    // reserved codes hold the last legal state
    if (nsttr_state_valid(target_state_in)) begin
      nxt_state = target_state_in;
    end
    nxt_auto = !nsttr_is_active(nxt_state);
    if (conv_done) begin
      nxt_conv = conv_data;
    end
    // only writable registers decode; others fall through untouched
    if (reg_wr_en) begin
      case (reg_addr)
        ADDR_TX_CNT_HIGH: nxt_cnt[TX_CNT_W-1 -: 8] = reg_wdata;
        ADDR_TX_CNT_LOW: begin
          nxt_cnt[4:0] = reg_wdata[7:TXLOW_CNT_LSB];
          nxt_res      = reg_wdata[TXLOW_RES_MSB:0];
        end
        ADDR_DAC_A: nxt_dac_a = reg_wdata;
        ADDR_DAC_B: nxt_dac_b = reg_wdata;
        default: ;
      endcase
    end
    // residual bits only honoured for ISO-A/B frames sent without crc
    if (tx_nocrc_cmd) begin
      nxt_last_bits = iso_ab_mode ? tx_residual_ff : 3'h0;
      nxt_par_gen   = !(iso_ab_mode && (tx_residual_ff != 3'h0));
      nxt_lsb_first = 1'b1;
    end else if (tx_crc_cmd) begin
      nxt_last_bits = 3'h0;
      nxt_par_gen   = 1'b1;
      nxt_lsb_first = 1'b1;
    end
    nxt_perr = reqa_wupa_cmd && anticoll_ctl && (state_ff == ST_IDLE)
               && (tx_residual_ff != 3'h0);
    if (reg_rd_en) begin
      case (reg_addr)
        ADDR_TARGET_STATE: nxt_rdata = {4'h0, state_ff};
        ADDR_TX_CNT_HIGH:  nxt_rdata = tx_byte_count_ff[12:5];
        ADDR_TX_CNT_LOW:   nxt_rdata = {tx_byte_count_ff[4:0], tx_residual_ff};
        ADDR_RATE_TIMER:   nxt_rdata = {2'h0, detected_rate, field_wait_timer_running,
                                        gp_timer_running, no_resp_timer_running,
                                        mask_rx_timer_running};
        ADDR_CONV_RESULT:  nxt_rdata = conv_ff;
        ADDR_DAC_A:        nxt_rdata = dac_a_code_ff;
        ADDR_DAC_B:        nxt_rdata = dac_b_code_ff;
        default:           nxt_rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff          <= STATE_RST;
      conv_ff           <= CONV_RST;
      tx_byte_count_ff  <= TX_CNT_RST;
      tx_residual_ff    <= TX_RES_RST;
      dac_a_code_ff     <= DAC_RST;
      dac_b_code_ff     <= DAC_RST;
      reg_rdata_ff      <= 8'h00;
      auto_answer_en_ff <= 1'b1;
      parity_err_irq_ff <= 1'b0;
      tx_last_bits_ff   <= TX_RES_RST;
      tx_parity_gen_ff  <= 1'b1;
      tx_lsb_first_ff   <= 1'b1;
    end else begin
      state_ff          <= nxt_state;
      conv_ff           <= nxt_conv;
      tx_byte_count_ff  <= nxt_cnt;
      tx_residual_ff    <= nxt_res;
      dac_a_code_ff     <= nxt_dac_a;
      dac_b_code_ff     <= nxt_dac_b;
      reg_rdata_ff      <= nxt_rdata;
      auto_answer_en_ff <= nxt_auto;
      parity_err_irq_ff <= nxt_perr;
      tx_last_bits_ff   <= nxt_last_bits;
      tx_parity_gen_ff  <= nxt_par_gen;
      tx_lsb_first_ff   <= nxt_lsb_first;
    end
  end

  // ==========================================================
  // assertions
  property p_state_legal;
    @(posedge clk) disable iff (sys_rst) nsttr_state_valid(state_ff);
  endproperty
  a_state_legal: assert property (p_state_legal) else $error("illegal state shown");

  property p_active_mute;
    @(posedge clk) disable iff (sys_rst)
      nsttr_is_active(state_ff) |-> !auto_answer_en_ff;
  endproperty
  a_active_mute: assert property (p_active_mute) else $error("auto answer in active");

  property p_cnt_high;
    @(posedge clk) disable iff (sys_rst)
      (reg_wr_en && reg_addr == ADDR_TX_CNT_HIGH) |=> (tx_byte_count_ff[12:5] == $past(reg_wdata));
  endproperty
  a_cnt_high: assert property (p_cnt_high) else $error("count high not written");

  property p_res_read;
    @(posedge clk) disable iff (sys_rst)
      (reg_rd_en && reg_addr == ADDR_TX_CNT_LOW && !reg_wr_en)
        |=> (reg_rdata_ff[2:0] == tx_residual_ff);
  endproperty
  a_res_read: assert property (p_res_read) else $error("residual readback wrong");

  property p_no_parity;
    @(posedge clk) disable iff (sys_rst)
      (tx_nocrc_cmd && iso_ab_mode && tx_residual_ff != 3'h0) |=> !tx_parity_gen_ff;
  endproperty
  a_no_parity: assert property (p_no_parity) else $error("parity kept on split byte");

  property p_perr;
    @(posedge clk) disable iff (sys_rst)
      (reqa_wupa_cmd && anticoll_ctl && state_ff == ST_IDLE && tx_residual_ff != 3'h0)
        |=> parity_err_irq_ff;
  endproperty
  a_perr: assert property (p_perr) else $error("parity error not raised");

  property p_short_iso;
    @(posedge clk) disable iff (sys_rst)
      (tx_nocrc_cmd && !iso_ab_mode) |=> (tx_last_bits_ff == 3'h0);
  endproperty
  a_short_iso: assert property (p_short_iso) else $error("split frame off ISO-A/B");

  property p_rate_read;
    @(posedge clk) disable iff (sys_rst)
      (reg_rd_en && reg_addr == ADDR_RATE_TIMER)
        |=> (reg_rdata_ff[5:4] == $past(detected_rate)) && (reg_rdata_ff[7:6] == 2'h0);
  endproperty
  a_rate_read: assert property (p_rate_read) else $error("rate readback wrong");

  property p_timer_read;
    @(posedge clk) disable iff (sys_rst)
      (reg_rd_en && reg_addr == ADDR_RATE_TIMER && field_wait_timer_running) |=> reg_rdata_ff[3];
  endproperty
  a_timer_read: assert property (p_timer_read) else $error("timer flag lost");

  property p_conv;
    @(posedge clk) disable iff (sys_rst) conv_done |=> (conv_ff == $past(conv_data));
  endproperty
  a_conv: assert property (p_conv) else $error("conversion not held");

  property p_dac_a;
    @(posedge clk) disable iff (sys_rst)
      (reg_wr_en && reg_addr == ADDR_DAC_A) |=> (dac_a_code_ff == $past(reg_wdata));
  endproperty
  a_dac_a: assert property (p_dac_a) else $error("dac a not written");

  property p_dac_b;
    @(posedge clk) disable iff (sys_rst)
      (!(reg_wr_en && reg_addr == ADDR_DAC_B)) |=> $stable(dac_b_code_ff);
  endproperty
  a_dac_b: assert property (p_dac_b) else $error("dac b changed unasked");

  property p_ro_read;
    @(posedge clk) disable iff (sys_rst)
      (reg_rd_en && reg_addr == ADDR_TARGET_STATE) |=> (reg_rdata_ff[7:4] == 4'h0);
  endproperty
  a_ro_read: assert property (p_ro_read) else $error("reserved bits not zero");

  c_perr: cover property (@(posedge clk) disable iff (sys_rst) parity_err_irq_ff);
  c_active: cover property (@(posedge clk) disable iff (sys_rst) !auto_answer_en_ff);
  c_split: cover property (@(posedge clk) disable iff (sys_rst) !tx_parity_gen_ff);
endmodule
`default_nettype wire

// File: sim/nsttr_host.sv
// host microcontroller model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module nsttr_host (
  input  wire logic       clk,
  output var  logic       wr_en,
  output var  logic       rd_en,
  output var  logic [7:0] addr,
  output var  logic [7:0] wdata,
  input  wire logic [7:0] rdata
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr  = 8'h00;
    wdata = 8'h00;
  end
  // ==========================================================
  // bus cycles; idle address is inverted after each access, write data after writes, so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    wr_en = 1'b1;
    addr  = a;
    wdata = d;
    @(posedge clk);
    #1;
    wr_en = 1'b0;
    addr  = ~a;
    wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    rd_en = 1'b1;
    addr  = a;
    @(posedge clk);
    #1;
    d     = rdata;
    rd_en = 1'b0;
    addr  = ~a;
  endtask
endmodule
`default_nettype wire

// File: sim/nsttr_regs_bench.sv
// self-checking bench for the status, transmit length and tuning registers
`timescale 1ns/1ps
`default_nettype none
module nsttr_regs_bench;
  import nsttr_pkg::*;
  logic        clk, sys_rst, wr_en, rd_en, conv_done, anticoll, reqa, nocrc, crc, iso_ab;
  logic        auto_ans, irq, par_gen, lsb_first;
  logic [1:0]  rate;
  logic [2:0]  res, last_bits;
  logic [3:0]  tstate, tmr;
  logic [7:0]  addr, wdata, rdata, conv, dac_a, dac_b;
  logic [12:0] cnt;
  int          mismatches, check_count;
  nsttr_host host_u (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
    .rdata(rdata));
  nsttr_regs dut_u (.clk(clk), .sys_rst(sys_rst), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata_ff(rdata), .target_state_in(tstate),
    .detected_rate(rate), .field_wait_timer_running(tmr[3]), .gp_timer_running(tmr[2]),
    .no_resp_timer_running(tmr[1]), .mask_rx_timer_running(tmr[0]), .conv_data(conv),
    .conv_done(conv_done), .anticoll_ctl(anticoll), .reqa_wupa_cmd(reqa),
    .tx_nocrc_cmd(nocrc), .tx_crc_cmd(crc), .iso_ab_mode(iso_ab), .auto_answer_en_ff(auto_ans),
    .parity_err_irq_ff(irq), .tx_byte_count_ff(cnt), .tx_residual_ff(res),
    .tx_last_bits_ff(last_bits), .tx_parity_gen_ff(par_gen), .tx_lsb_first_ff(lsb_first),
    .dac_a_code_ff(dac_a), .dac_b_code_ff(dac_b));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // helpers
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd_chk(ADDR_TX_CNT_HIGH, 8'h00);
    rd_chk(ADDR_TX_CNT_LOW, 8'h00);
    rd_chk(ADDR_DAC_A, DAC_RST);
    rd_chk(ADDR_DAC_B, DAC_RST);
    rd_chk(8'h28, 8'h00);
  endtask
  task automatic t_write();
    host_u.wr(ADDR_TX_CNT_HIGH, 8'hFF);
    host_u.wr(ADDR_TX_CNT_LOW, 8'hFD);
    chk({3'h0, cnt}, 16'h1FFF);
    chk({13'h0, res}, 16'h0005);
    rd_chk(ADDR_TX_CNT_LOW, 8'hFD);
    host_u.wr(ADDR_DAC_A, 8'h12);
    host_u.wr(ADDR_DAC_B, 8'hED);
    chk({dac_a, dac_b}, 16'h12ED);
    rd_chk(ADDR_DAC_B, 8'hED);
    host_u.wr(ADDR_TARGET_STATE, 8'hFF);
    host_u.wr(ADDR_CONV_RESULT, 8'hFF);
    rd_chk(ADDR_TARGET_STATE, 8'h00);
    rd_chk(ADDR_CONV_RESULT, CONV_RST);
  endtask
  task automatic t_status();
    tstate = ST_ACTIVE;
    step(2);
    chk({15'h0, auto_ans}, 16'h0000);
    rd_chk(ADDR_TARGET_STATE, 8'h05);
    tstate = 4'h4;
    step(2);
    rd_chk(ADDR_TARGET_STATE, 8'h05);
    tstate = ST_ACTIVE_S;
    step(2);
    chk({15'h0, auto_ans}, 16'h0000);
    tstate = ST_IDLE;
    step(2);
    chk({15'h0, auto_ans}, 16'h0001);
    rate = 2'h2;
    tmr = 4'hA;
    host_u.wr(ADDR_RATE_TIMER, 8'hFF);
    rd_chk(ADDR_RATE_TIMER, 8'h2A);
    tmr = 4'h5;
    rd_chk(ADDR_RATE_TIMER, 8'h25);
  endtask
  task automatic t_conv();
    conv = 8'hA5;
    conv_done = 1'b1;
    step(1);
    conv_done = 1'b0;
    conv = 8'h5A;
    rd_chk(ADDR_CONV_RESULT, 8'hA5);
  endtask
  task automatic t_cmds();
    anticoll = 1'b1;
    reqa = 1'b1;
    step(1);
    chk({15'h0, irq}, 16'h0001);
    reqa = 1'b0;
    anticoll = 1'b0;
    step(1);
    chk({15'h0, irq}, 16'h0000);
    // same command without the anticollision bit must stay quiet
    reqa = 1'b1;
    step(1);
    reqa = 1'b0;
    chk({15'h0, irq}, 16'h0000);
    iso_ab = 1'b1;
    host_u.wr(ADDR_TX_CNT_LOW, 8'hFC);
    nocrc = 1'b1;
    step(1);
    nocrc = 1'b0;
    chk({11'h000, last_bits, par_gen, lsb_first}, 16'h0011);
    crc = 1'b1;
    step(1);
    crc = 1'b0;
    chk({12'h000, last_bits, par_gen}, 16'h0001);
    nocrc = 1'b1;
    step(1);
    nocrc = 1'b0;
    chk({12'h000, last_bits, par_gen}, 16'h0008);
    // outside ISO-A/B the residual count must be dropped
    iso_ab = 1'b0;
    nocrc = 1'b1;
    step(1);
    nocrc = 1'b0;
    chk({12'h000, last_bits, par_gen}, 16'h0001);
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence; a second reset at the end checks registers fall back
  initial begin
    {sys_rst, conv_done, anticoll, reqa, nocrc, crc, iso_ab} = 7'h40;
    {tstate, tmr, rate, conv} = 18'h00000;
    repeat (6) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    t_reset();
    t_write();
    t_status();
    t_conv();
    t_cmds();
    sys_rst = 1'b1;
    step(2);
    sys_rst = 1'b0;
    chk({dac_a, cnt[7:0]}, 16'h8000);
    report_and_stop();
  end
  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end
endmodule
`default_nettype wire
